// ===== design/sprc_consts.svh
`ifndef SPRC_CONSTS_SVH
`define SPRC_CONSTS_SVH
`define SPRC_A_CTRL       8'h00
`define SPRC_A_PORT       8'h04
`define SPRC_A_STATUS     8'h08
`define SPRC_A_IRQ_STAT   8'h0C
`define SPRC_A_IRQ_MASK   8'h10
`define SPRC_A_MSI        8'h14
`define SPRC_A_PWR        8'h18
`define SPRC_B_SRC        0
`define SPRC_B_INTSEL     1
`define SPRC_B_PHYRST     2
`define SPRC_B_HR         3
`define SPRC_B_SHADOW     4
`define SPRC_B_IDE        5
`define SPRC_DIV_48       2'h0
`define SPRC_DIV_100      2'h2
`define SPRC_FB_48        8'h7D
`define SPRC_FB_100       8'h3C
`define SPRC_DET_OFF      4'h4
`define SPRC_DET_ON       4'h1
`define SPRC_ICC_ACTIVE   4'h1
`define SPRC_ICC_PARTIAL  4'h2
`define SPRC_ICC_SLUMBER  4'h6
`define SPRC_HR_CYCLES    16
`define SPRC_CTRL_RESET   32'h0000_0014
`endif

// ===== design/sprc_pkg.sv
package sprc_pkg;
    typedef enum logic [5:0] {
        SPRC_PS_ACTIVE  = 6'b000001,
        SPRC_PS_LIMITED = 6'b000010,
        SPRC_PS_PARTIAL = 6'b000100,
        SPRC_PS_SLUMBER = 6'b001000,
        SPRC_PS_LANEOFF = 6'b010000,
        SPRC_PS_DOWN    = 6'b100000
    } sprc_pstate_t;
    typedef enum logic [1:0] {
        SPRC_HR_IDLE = 2'b01,
        SPRC_HR_BUSY = 2'b10
    } sprc_hr_t;
endpackage

// ===== design/sprc_top.sv
`timescale 1ns/1ps
`include "sprc_consts.svh"
module sprc_top
    import sprc_pkg::*;
#(
    parameter int NPORTS = 2
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Events from the controller, asynchronous
    input  wire logic        parity_error_in,
    input  wire logic        ras_event_in,
    // PHY controls and interrupt
    output logic             phy_ref_clock_source,
    output logic             internal_ref_clock_select,
    output logic [1:0]       phy_ref_divider_select,
    output logic [7:0]       pll_feedback_divider,
    output logic             phy_reset_n,
    output logic             host_reset,
    output logic             shadow_reload_disable,
    output logic             msi_cap_hidden,
    output logic [3:0]       port_det_0,
    output logic [3:0]       port_det_1,
    output logic             limit_second_generation,
    output logic [3:0]       port_icc,
    output logic             port_disable_control,
    output logic             phy_power_control,
    output logic             irq
);
    // Only two port fields exist in the port register.
    if (NPORTS < 1 || NPORTS > 2) begin : g_bad_nports
        $error("NPORTS must be 1 or 2");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]  ctrl_q;
    logic [7:0]   port_q;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    logic [2:0]   msi_mmc_q;
    sprc_pstate_t pstate_q;
    sprc_hr_t     hr_state_q;
    logic [4:0]   hr_cnt_q;
    logic [1:0]   ev_s1_q;
    logic [1:0]   ev_s2_q;

    logic aw_q;
    logic w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        rd_fire;

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == `SPRC_A_CTRL) || (a == `SPRC_A_PORT) ||
                     (a == `SPRC_A_STATUS) || (a == `SPRC_A_IRQ_STAT) ||
                     (a == `SPRC_A_IRQ_MASK) || (a == `SPRC_A_MSI) ||
                     (a == `SPRC_A_PWR);
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    assign s_axi_awready = clk_en && !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = clk_en && !w_q && !s_axi_bvalid;
    assign wr_fire       = clk_en && aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(awaddr_q) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte strobes are honoured only as a whole word; partial writes to
    // these control words would split fields that must change together.
    // The strobes are kept with the data, as the master may move on early.
    logic wr_ok;
    assign wr_ok = wr_fire && (wstrb_q == 4'hF);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SPRC_CTRL_RESET;
        end else if (clk_en) begin
            if (wr_ok && awaddr_q == `SPRC_A_CTRL) begin
                ctrl_q <= wdata_q;
            end else if (hr_state_q == SPRC_HR_BUSY &&
                         hr_cnt_q == 5'(`SPRC_HR_CYCLES - 1)) begin
                ctrl_q[`SPRC_B_HR] <= 1'b0;
            end
            if (wr_ok && awaddr_q == `SPRC_A_CTRL && wdata_q[`SPRC_B_HR]) begin
                ctrl_q[`SPRC_B_HR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port_q     <= {`SPRC_DET_ON, `SPRC_DET_ON};
            irq_mask_q <= 2'h0;
            msi_mmc_q  <= 3'h0;
            pstate_q   <= SPRC_PS_ACTIVE;
        end else if (clk_en && wr_ok) begin
            if (awaddr_q == `SPRC_A_PORT) begin
                port_q <= wdata_q[7:0];
            end
            if (awaddr_q == `SPRC_A_IRQ_MASK) begin
                irq_mask_q <= wdata_q[1:0];
            end
            if (awaddr_q == `SPRC_A_MSI) begin
                msi_mmc_q <= wdata_q[2:0];
            end
            if (awaddr_q == `SPRC_A_PWR) begin
                unique case (wdata_q[5:0])
                    6'b000001: pstate_q <= SPRC_PS_ACTIVE;
                    6'b000010: pstate_q <= SPRC_PS_LIMITED;
                    6'b000100: pstate_q <= SPRC_PS_PARTIAL;
                    6'b001000: pstate_q <= SPRC_PS_SLUMBER;
                    6'b010000: pstate_q <= SPRC_PS_LANEOFF;
                    6'b100000: pstate_q <= SPRC_PS_DOWN;
                    default:   pstate_q <= pstate_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Host reset sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hr_state_q <= SPRC_HR_IDLE;
            hr_cnt_q   <= 5'h00;
        end else if (clk_en) begin
            unique case (hr_state_q)
                SPRC_HR_IDLE: begin
                    hr_cnt_q <= 5'h00;
                    if (ctrl_q[`SPRC_B_HR]) begin
                        hr_state_q <= SPRC_HR_BUSY;
                    end
                end
                SPRC_HR_BUSY: begin
                    hr_cnt_q <= hr_cnt_q + 5'h01;
                    if (hr_cnt_q == 5'(`SPRC_HR_CYCLES - 1)) begin
                        hr_state_q <= SPRC_HR_IDLE;
                    end
                end
                default: hr_state_q <= SPRC_HR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    logic rd_stat;
    assign rd_stat = rd_fire && s_axi_araddr[7:2] == `SPRC_A_IRQ_STAT >> 2;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ev_s1_q    <= 2'h0;
            ev_s2_q    <= 2'h0;
            irq_stat_q <= 2'h0;
        end else if (clk_en) begin
            ev_s1_q <= {ras_event_in, parity_error_in};
            ev_s2_q <= ev_s1_q;
            // A new event in the clearing cycle survives the read.
            irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | ev_s2_q;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (clk_en) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= known_addr({s_axi_araddr[7:2], 2'b00}) ?
                                2'h0 : 2'h2;
                unique case ({s_axi_araddr[7:2], 2'b00})
                    `SPRC_A_CTRL:     s_axi_rdata <= ctrl_q;
                    `SPRC_A_PORT:     s_axi_rdata <= {24'h0, port_q};
                    `SPRC_A_STATUS:   s_axi_rdata <= {22'h0, ev_s2_q,
                                          pll_feedback_divider};
                    `SPRC_A_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_q};
                    `SPRC_A_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
                    `SPRC_A_MSI:      s_axi_rdata <= {29'h0, msi_mmc_q};
                    `SPRC_A_PWR:      s_axi_rdata <= {26'h0, pstate_q};
                    default:          s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // PHY control outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phy_ref_divider_select <= `SPRC_DIV_48;
            pll_feedback_divider   <= `SPRC_FB_48;
        end else if (clk_en) begin
            if (ctrl_q[`SPRC_B_SRC]) begin
                phy_ref_divider_select <= `SPRC_DIV_100;
                pll_feedback_divider   <= `SPRC_FB_100;
            end else begin
                phy_ref_divider_select <= `SPRC_DIV_48;
                pll_feedback_divider   <= `SPRC_FB_48;
            end
        end
    end

    assign phy_ref_clock_source      = ctrl_q[`SPRC_B_SRC];
    assign internal_ref_clock_select = ctrl_q[`SPRC_B_INTSEL];
    assign phy_reset_n               = ctrl_q[`SPRC_B_PHYRST];
    assign host_reset                = hr_state_q == SPRC_HR_BUSY;
    assign shadow_reload_disable     = ctrl_q[`SPRC_B_SHADOW];
    assign msi_cap_hidden            = ctrl_q[`SPRC_B_IDE];
    assign port_det_0                = port_q[3:0];
    assign port_det_1                = (NPORTS > 1) ? port_q[7:4] :
                                       `SPRC_DET_OFF;

    // Power state encoding; ICC holds its active value where don't-care.
    always_comb begin
        limit_second_generation = 1'b0;
        port_icc                = `SPRC_ICC_ACTIVE;
        port_disable_control    = 1'b0;
        phy_power_control       = 1'b1;
        unique case (pstate_q)
            SPRC_PS_ACTIVE:  port_icc = `SPRC_ICC_ACTIVE;
            SPRC_PS_LIMITED: limit_second_generation = 1'b1;
            SPRC_PS_PARTIAL: port_icc = `SPRC_ICC_PARTIAL;
            SPRC_PS_SLUMBER: port_icc = `SPRC_ICC_SLUMBER;
            SPRC_PS_LANEOFF: port_disable_control = 1'b1;
            SPRC_PS_DOWN: begin
                port_disable_control = 1'b1;
                phy_power_control    = 1'b0;
            end
        endcase
    end
endmodule

// ===== tb/sprc_top_monitor.sv
`timescale 1ns/1ps
module sprc_top_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // Bus responses
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // PHY controls
    input wire logic        phy_ref_clock_source,
    input wire logic [1:0]  phy_ref_divider_select,
    input wire logic [7:0]  pll_feedback_divider,
    input wire logic        host_reset,
    input wire logic        shadow_reload_disable,
    input wire logic        limit_second_generation,
    input wire logic [3:0]  port_icc,
    input wire logic        port_disable_control,
    input wire logic        phy_power_control
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!resetn);
// Counts consecutive host reset cycles so the pulse length can be bounded.
logic [4:0] hr_cnt_q;
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hr_cnt_q <= 5'h00;
    else if (host_reset) hr_cnt_q <= hr_cnt_q + 5'h01;
    else hr_cnt_q <= 5'h00;
end
sequence s_hr_start; $rose(host_reset); endsequence
sequence s_hr_hold; host_reset [*8]; endsequence
a_hr_min_len: assert property (s_hr_start |-> s_hr_hold)
    else $error("host reset pulse too short");
a_hr_exact_len: assert property ($fell(host_reset) |-> hr_cnt_q == 5'h10)
    else $error("host reset pulse length wrong");
a_hr_bound: assert property (hr_cnt_q <= 5'h10)
    else $error("host reset pulse too long");
a_src_fast_div: assert property (phy_ref_clock_source &&
    $past(phy_ref_clock_source) |->
    phy_ref_divider_select == 2'h2 && pll_feedback_divider == 8'h3C)
    else $error("dividers wrong for fast source");
a_src_slow_div: assert property (!phy_ref_clock_source &&
    !$past(phy_ref_clock_source) |->
    phy_ref_divider_select == 2'h0 && pll_feedback_divider == 8'h7D)
    else $error("dividers wrong for slow source");
a_reset_vals: assert property ($rose(resetn) |->
    shadow_reload_disable && !phy_ref_clock_source)
    else $error("control values wrong after reset");
a_pwr_off_dis: assert property (!phy_power_control |->
    port_disable_control)
    else $error("power down without port disable");
a_limit_active: assert property (limit_second_generation |->
    port_icc == 4'h1 && !port_disable_control && phy_power_control)
    else $error("limited state encoding wrong");
a_icc_legal: assert property (!port_disable_control |->
    port_icc inside {4'h1, 4'h2, 4'h6})
    else $error("lane enabled with illegal icc");
a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
endmodule
bind sprc_top sprc_top_monitor u_mon (.ref_clk, .resetn, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .phy_ref_clock_source, .phy_ref_divider_select, .pll_feedback_divider,
    .host_reset, .shadow_reload_disable, .limit_second_generation,
    .port_icc, .port_disable_control, .phy_power_control);

// ===== tb/sprc_top_tb.sv
`timescale 1ns/1ps
`include "sprc_consts.svh"
module sprc_top_tb;
logic ref_clk = 0, resetn = 0, clk_en = 1;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
logic [3:0] s_axi_wstrb = 4'hF, port_det_0, port_det_1, port_icc;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0, parity_error_in = 0;
logic ras_event_in = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
logic s_axi_arready, s_axi_rvalid, phy_ref_clock_source, phy_reset_n;
logic [1:0] s_axi_bresp, s_axi_rresp, phy_ref_divider_select, resp_v;
logic [7:0] pll_feedback_divider;
logic internal_ref_clock_select, host_reset, shadow_reload_disable;
logic msi_cap_hidden, limit_second_generation, port_disable_control;
logic phy_power_control, irq;
int mismatches = 0, num_checks = 0, hr_seen = 0;
sprc_top uut (.*);
always #50 ref_clk = ~ref_clk;
always @(negedge ref_clk) if (host_reset) hr_seen++;
// ----------------------------------------
// Checking and bus tasks
// ----------------------------------------
task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
        mismatches++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
endtask
// Ready is sampled at the falling edge, where it already holds the value
// that the next rising edge sees, so no race with the design's updates.
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
        @(negedge ref_clk);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid;
        if (tb) resp_v = s_axi_bresp;
        @(posedge ref_clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
        n++;
        if (n > 40) begin
            chk("write wait", 0, 1);
            end_sim();
        end
    end
endtask
task automatic rd(input logic [7:0] a);
    bit ta, got;
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
        @(negedge ref_clk);
        ta = s_axi_arvalid && s_axi_arready;
        got = s_axi_rvalid;
        if (got) begin
            rd_v = s_axi_rdata;
            resp_v = s_axi_rresp;
        end
        @(posedge ref_clk);
        if (ta) s_axi_arvalid <= 1'b0;
        if (got) s_axi_rready <= 1'b0;
        n++;
        if (n > 40) begin
            chk("read wait", 0, 1);
            end_sim();
        end
    end
endtask
task automatic rdx(input logic [7:0] a, input logic [31:0] e, string nm);
    rd(a);
    chk(nm, rd_v, e);
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_reset();
    chk("src", phy_ref_clock_source, 0);
    chk("div", phy_ref_divider_select, `SPRC_DIV_48);
    chk("fb", pll_feedback_divider, `SPRC_FB_48);
    chk("shadow", shadow_reload_disable, 1);
    chk("icc", port_icc, `SPRC_ICC_ACTIVE);
    rdx(`SPRC_A_CTRL, `SPRC_CTRL_RESET, "ctrl");
    $display("test reset done");
endtask
task automatic t_clock();
    wr(`SPRC_A_PORT, 32'h44);
    chk("det off", {port_det_1, port_det_0}, 8'h44);
    wr(`SPRC_A_CTRL, 32'h13);
    chk("phy reset held", phy_reset_n, 0);
    repeat (2) @(posedge ref_clk);
    chk("intsel", internal_ref_clock_select, 1);
    chk("div", phy_ref_divider_select, `SPRC_DIV_100);
    chk("fb", pll_feedback_divider, `SPRC_FB_100);
    rdx(`SPRC_A_STATUS, 32'h3C, "status");
    wr(`SPRC_A_PORT, 32'h11);
    chk("det", {port_det_1, port_det_0}, 8'h11);
    repeat (1000) @(posedge ref_clk);
    wr(`SPRC_A_CTRL, 32'h17);
    chk("phy reset", phy_reset_n, 1);
    wr(`SPRC_A_CTRL, 32'h16);
    repeat (2) @(posedge ref_clk);
    chk("div", phy_ref_divider_select, `SPRC_DIV_48);
    chk("fb", pll_feedback_divider, `SPRC_FB_48);
    wr(`SPRC_A_CTRL, 32'h17);
    $display("test clock done");
endtask
task automatic t_hr();
    hr_seen = 0;
    wr(`SPRC_A_CTRL, 32'h1F);
    repeat (40) @(posedge ref_clk);
    chk("hr cycles", hr_seen, `SPRC_HR_CYCLES);
    rdx(`SPRC_A_CTRL, 32'h17, "hr clear");
    $display("test host reset done");
endtask
task automatic t_pwr();
    logic [5:0] st[7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h03};
    logic [5:0] e[7] = '{6'h05, 6'h05, 6'h09, 6'h19, 6'h03, 6'h02, 6'h02};
    logic [5:0] m[7] = '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h03, 6'h03, 6'h03};
    logic [5:0] v;
    for (int i = 0; i < 7; i++) begin
        wr(`SPRC_A_PWR, {26'h0, st[i]});
        v = {port_icc, port_disable_control, phy_power_control};
        chk("pwr", v & m[i], e[i]);
        if (i < 2) chk("limit", limit_second_generation, i);
    end
    $display("test power done");
endtask
task automatic t_misc();
    wr(`SPRC_A_CTRL, 32'h27);
    chk("msi hide", msi_cap_hidden, 1);
    chk("shadow", shadow_reload_disable, 0);
    wr(`SPRC_A_MSI, 32'h2);
    rdx(`SPRC_A_MSI, 32'h2, "mmc");
    rdx(8'h40, 32'h0, "unmapped data");
    chk("unmapped rresp", resp_v, 2'h2);
    wr(8'h40, 32'h5);
    chk("unmapped bresp", resp_v, 2'h2);
    $display("test misc done");
endtask
task automatic t_irq();
    wr(`SPRC_A_IRQ_MASK, 32'h1);
    parity_error_in <= 1'b1;
    @(posedge ref_clk) parity_error_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("irq set", irq, 1);
    rdx(`SPRC_A_IRQ_STAT, 32'h1, "stat parity");
    repeat (2) @(posedge ref_clk);
    chk("irq clear", irq, 0);
    ras_event_in <= 1'b1;
    @(posedge ref_clk) ras_event_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("irq masked", irq, 0);
    rdx(`SPRC_A_IRQ_STAT, 32'h2, "stat ras");
    // A pulse while the enable is low must not reach the frozen synchroniser.
    clk_en <= 1'b0;
    parity_error_in <= 1'b1;
    @(posedge ref_clk) parity_error_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clk_en <= 1'b1;
    rdx(`SPRC_A_IRQ_STAT, 32'h0, "frozen event");
    chk("frozen irq", irq, 0);
    $display("test interrupt done");
endtask
initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_clock();
    t_hr();
    t_pwr();
    t_misc();
    t_irq();
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    end_sim();
end
endmodule
